/* common/rfsc_pkg.sv */
/*
  rfsc_pkg: register map, field positions, mode-dependent reset values and
  shared types of the receiver serial control port.
  Assumes a single clock domain; the serial pins are sampled by the system clock.
*/
package rfsc_pkg;

  // serial framing
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int READ_BIT = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // register offsets (address with the direction bit stripped)
  localparam logic [6:0] OFS_FB_HIGH = 7'h40;
  localparam logic [6:0] OFS_FB_LOW = 7'h41;
  localparam logic [6:0] OFS_REF_DIV = 7'h42;
  localparam logic [6:0] OFS_RADIO_CFG = 7'h43;
  localparam logic [6:0] OFS_TEST = 7'h50;
  localparam logic [6:0] OFS_BLOCK_EN = 7'h51;
  localparam logic [6:0] OFS_LOOP_PUMP = 7'h52;
  localparam logic [6:0] OFS_RF_SECTION_ENABLE_PIN = 7'h60;

  // storable bits of each register; the rest read as zero
  localparam logic [7:0] MASK_FB_HIGH = 8'h0f;
  localparam logic [7:0] MASK_FB_LOW = 8'hff;
  localparam logic [7:0] MASK_REF_DIV = 8'h3f;
  localparam logic [7:0] MASK_RADIO_CFG = 8'hff;
  localparam logic [7:0] MASK_TEST = 8'h7f;
  localparam logic [7:0] MASK_BLOCK_EN = 8'hff;
  localparam logic [7:0] MASK_LOOP_PUMP = 8'h7f;
  localparam logic [7:0] MASK_RF_SECTION_ENABLE_PIN = 8'hbf;

  // reset values: DEF0 for mode low (16.368 MHz), DEF1 for mode high (19.2 MHz)
  localparam logic [7:0] DEF0_FB_HIGH = 8'h00;
  localparam logic [7:0] DEF1_FB_HIGH = 8'h06;
  localparam logic [7:0] DEF0_FB_LOW = 8'h60;
  localparam logic [7:0] DEF1_FB_LOW = 8'h13;
  localparam logic [7:0] DEF0_REF_DIV = 8'h01;
  localparam logic [7:0] DEF1_REF_DIV = 8'h13;
  localparam logic [7:0] DEF0_RADIO_CFG = 8'h4a;
  localparam logic [7:0] DEF1_RADIO_CFG = 8'h4f;
  localparam logic [7:0] DEF_TEST = 8'h00;
  localparam logic [7:0] DEF_BLOCK_EN = 8'hff;
  localparam logic [7:0] DEF_LOOP_PUMP = 8'h00;
  localparam logic [7:0] DEF_RF_SECTION_ENABLE_PIN = 8'h00;

  // field positions
  localparam int CFG_SRC_BIT = 0;
  localparam int CFG_SLEW_BIT = 1;
  localparam int CFG_OSC_BIT = 2;
  localparam int CFG_SAMPLE_BIT = 3;
  localparam int TEST_IFB_BIT = 0;
  localparam int BLK_VCO_BIT = 0;
  localparam int BLK_PLL_BIT = 1;
  localparam int BLK_RFA_BIT = 2;
  localparam int BLK_MIX_BIT = 3;
  localparam int BLK_IF_BIT = 4;
  localparam int BLK_AGC_BIT = 5;
  localparam int BLK_ENM_BIT = 7;
  localparam int LOOP_LFC_LSB = 2;
  localparam int RFE_BIT = 7;

  typedef enum logic [1:0] {
    PHASE_ADDR,
    PHASE_DATA,
    PHASE_DONE
  } rfsc_phase_type;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [7:0] data;
  } rfsc_wr_type;

  typedef struct packed {
    logic chip_active;
    logic rf_chain_on;
    logic vco_on;
    logic pll_on;
    logic rf_amp_on;
    logic mixer_on;
    logic if_chain_on;
    logic agc_on;
    logic clock_out_source_select;
    logic slow_slew_select;
    logic osc_clock_buffer_enable;
    logic sample_clock_buffer_enable;
    logic if_buffer_enable;
    logic [2:0] loop_filter_setting;
    logic [1:0] pump_current_setting;
    logic [11:0] feedback_divide_ratio;
    logic [5:0] reference_divide_ratio;
  } rfsc_ctrl_type;

endpackage

/* rtl/rfsc_shifter.sv */
/*
  rfsc_shifter: serial frame engine, address byte then data byte, msb first.
  Assumes the serial pins are synchronous to sys_clk and the serial clock idles low.
*/
`timescale 1ns/100ps
module rfsc_shifter (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // serial pins
  input wire logic link_on,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic serial_data_in_pin,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // register side
  input wire logic [7:0] rd_data,
  output logic [7:0] addr,
  output rfsc_pkg::rfsc_wr_type wr
);

  logic sck_prev, next_sck_prev;
  rfsc_pkg::rfsc_phase_type phase, next_phase;
  logic [2:0] cnt, next_cnt;
  logic [7:0] in_sh, next_in_sh;
  logic [7:0] next_addr;
  logic [7:0] out_sh, next_out_sh;
  logic next_oe;
  rfsc_pkg::rfsc_wr_type next_wr;
  logic sck_rise, sck_fall, reading;

  assign sck_rise = spi_sck & ~sck_prev;
  assign sck_fall = ~spi_sck & sck_prev;
  assign reading = addr[rfsc_pkg::READ_BIT];
  assign spi_sdo = out_sh[7];

  always_comb begin
    next_sck_prev = spi_sck;
    next_phase = phase;
    next_cnt = cnt;
    next_in_sh = in_sh;
    next_addr = addr;
    next_out_sh = out_sh;
    next_oe = spi_sdo_oe;
    next_wr = wr;
    next_wr.valid = 1'b0;
    if (!link_on) begin
      next_phase = rfsc_pkg::PHASE_ADDR;
      next_cnt = '0;
      next_oe = 1'b0;
    end else if (sck_rise) begin
      next_in_sh = {in_sh[6:0], serial_data_in_pin};
      next_cnt = cnt + 3'h1;
      if (cnt == rfsc_pkg::LAST_BIT) begin
        case (phase)
          rfsc_pkg::PHASE_ADDR: begin
            next_addr = {in_sh[6:0], serial_data_in_pin};
            next_phase = rfsc_pkg::PHASE_DATA;
          end
          rfsc_pkg::PHASE_DATA: begin
            if (!reading) begin
              next_wr.valid = 1'b1;
              next_wr.addr = addr[6:0];
              next_wr.data = {in_sh[6:0], serial_data_in_pin};
            end
            next_phase = rfsc_pkg::PHASE_DONE;
          end
          default: begin
            next_phase = rfsc_pkg::PHASE_DONE;
          end
        endcase
      end
    end else if (sck_fall && phase == rfsc_pkg::PHASE_DATA && reading) begin
      // data phase of a read: drive d7 at the first falling edge, shift after
      if (cnt == '0) begin
        next_out_sh = rd_data;
        next_oe = 1'b1;
      end else begin
        next_out_sh = {out_sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev <= 1'b0;
      phase <= rfsc_pkg::PHASE_ADDR;
      cnt <= '0;
      in_sh <= '0;
      addr <= '0;
      out_sh <= '0;
      spi_sdo_oe <= 1'b0;
      wr <= '0;
    end else begin
      sck_prev <= next_sck_prev;
      phase <= next_phase;
      cnt <= next_cnt;
      in_sh <= next_in_sh;
      addr <= next_addr;
      out_sh <= next_out_sh;
      spi_sdo_oe <= next_oe;
      wr <= next_wr;
    end
  end

  chk_sdo_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
    spi_cs_n && $past(spi_cs_n) |-> !spi_sdo_oe)
    else $error("serial output driven while chip select is high");

  chk_read_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(spi_sdo_oe) |-> reading && phase == rfsc_pkg::PHASE_DATA && cnt == '0)
    else $error("serial output enabled outside a read data phase");

  chk_write_dir: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr.valid |-> !addr[rfsc_pkg::READ_BIT] && addr[6:0] == wr.addr
      && $past(phase) == rfsc_pkg::PHASE_DATA)
    else $error("write strobe without a write address byte");

endmodule

/* rtl/rfsc_top.sv */
/*
  rfsc_top: serial control port and configuration registers of the receiver.
  Assumes every pin is synchronous to sys_clk; the controller is the serial master.
*/
`timescale 1ns/100ps
module rfsc_top #(
  parameter logic [7:0] LOOP_PUMP_DEFAULT = rfsc_pkg::DEF_LOOP_PUMP
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control pins
  input wire logic mode_pin,
  input wire logic rf_section_enable_pin,
  input wire logic chip_enable_pin,
  // serial port
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic serial_data_in_pin,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // synthesizer and block controls
  output logic [23:0] pll_word,
  output rfsc_pkg::rfsc_ctrl_type ctrl
);

  function automatic logic [7:0] by_mode(input logic m, input logic [7:0] d0,
                                         input logic [7:0] d1);
    by_mode = m ? d1 : d0;
  endfunction

  logic ce_prev, next_ce_prev;
  logic init_pending, next_init_pending;
  logic load_defaults;
  logic link_on;
  logic [7:0] spi_addr;
  logic [7:0] rd_data;
  rfsc_pkg::rfsc_wr_type wr;

  logic [7:0] fb_divider_high, next_fb_divider_high;
  logic [7:0] fb_divider_low, next_fb_divider_low;
  logic [7:0] ref_divider, next_ref_divider;
  logic [7:0] radio_config, next_radio_config;
  logic [7:0] test_control, next_test_control;
  logic [7:0] block_enables, next_block_enables;
  logic [7:0] loop_filter_pump, next_loop_filter_pump;
  logic [7:0] rf_enable_control, next_rf_enable_control;
  logic [23:0] next_pll_word;
  rfsc_pkg::rfsc_ctrl_type next_ctrl;
  logic rf_active;

  // the port ignores frames while the chip is disabled
  assign link_on = ~spi_cs_n & chip_enable_pin;
  assign load_defaults = init_pending | (chip_enable_pin & ~ce_prev);

  rfsc_shifter rfsc_shifter_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .link_on(link_on),
    .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck),
    .serial_data_in_pin(serial_data_in_pin),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .rd_data(rd_data),
    .addr(spi_addr),
    .wr(wr)
  );

  // edge detect on chip enable; the first cycle after reset also loads defaults
  always_comb begin
    next_ce_prev = chip_enable_pin;
    next_init_pending = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_prev <= 1'b0;
      init_pending <= 1'b1;
    end else begin
      ce_prev <= next_ce_prev;
      init_pending <= next_init_pending;
    end
  end

  // register file
  always_comb begin
    next_fb_divider_high = fb_divider_high;
    next_fb_divider_low = fb_divider_low;
    next_ref_divider = ref_divider;
    next_radio_config = radio_config;
    next_test_control = test_control;
    next_block_enables = block_enables;
    next_loop_filter_pump = loop_filter_pump;
    next_rf_enable_control = rf_enable_control;
    next_pll_word = pll_word;
    if (load_defaults) begin
      next_fb_divider_high = by_mode(mode_pin, rfsc_pkg::DEF0_FB_HIGH,
                                     rfsc_pkg::DEF1_FB_HIGH);
      next_fb_divider_low = by_mode(mode_pin, rfsc_pkg::DEF0_FB_LOW,
                                    rfsc_pkg::DEF1_FB_LOW);
      next_ref_divider = by_mode(mode_pin, rfsc_pkg::DEF0_REF_DIV,
                                 rfsc_pkg::DEF1_REF_DIV);
      next_radio_config = by_mode(mode_pin, rfsc_pkg::DEF0_RADIO_CFG,
                                  rfsc_pkg::DEF1_RADIO_CFG);
      next_test_control = rfsc_pkg::DEF_TEST;
      next_block_enables = rfsc_pkg::DEF_BLOCK_EN;
      next_loop_filter_pump = LOOP_PUMP_DEFAULT & rfsc_pkg::MASK_LOOP_PUMP;
      next_rf_enable_control = rfsc_pkg::DEF_RF_SECTION_ENABLE_PIN;
      next_rf_enable_control[rfsc_pkg::RFE_BIT] = rf_section_enable_pin;
      next_pll_word = {next_fb_divider_high, next_fb_divider_low, next_ref_divider};
    end else if (wr.valid) begin
      if (wr.addr == rfsc_pkg::OFS_FB_HIGH) begin
        next_fb_divider_high = wr.data & rfsc_pkg::MASK_FB_HIGH;
      end else if (wr.addr == rfsc_pkg::OFS_FB_LOW) begin
        next_fb_divider_low = wr.data & rfsc_pkg::MASK_FB_LOW;
      end else if (wr.addr == rfsc_pkg::OFS_REF_DIV) begin
        next_ref_divider = wr.data & rfsc_pkg::MASK_REF_DIV;
        next_pll_word = {fb_divider_high, fb_divider_low, next_ref_divider};
      end else if (wr.addr == rfsc_pkg::OFS_RADIO_CFG) begin
        next_radio_config = wr.data & rfsc_pkg::MASK_RADIO_CFG;
      end else if (wr.addr == rfsc_pkg::OFS_TEST) begin
        next_test_control = wr.data & rfsc_pkg::MASK_TEST;
      end else if (wr.addr == rfsc_pkg::OFS_BLOCK_EN) begin
        next_block_enables = wr.data & rfsc_pkg::MASK_BLOCK_EN;
      end else if (wr.addr == rfsc_pkg::OFS_LOOP_PUMP) begin
        next_loop_filter_pump = wr.data & rfsc_pkg::MASK_LOOP_PUMP;
      end else if (wr.addr == rfsc_pkg::OFS_RF_SECTION_ENABLE_PIN) begin
        next_rf_enable_control = wr.data & rfsc_pkg::MASK_RF_SECTION_ENABLE_PIN;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_divider_high <= rfsc_pkg::DEF0_FB_HIGH;
      fb_divider_low <= rfsc_pkg::DEF0_FB_LOW;
      ref_divider <= rfsc_pkg::DEF0_REF_DIV;
      radio_config <= rfsc_pkg::DEF0_RADIO_CFG;
      test_control <= rfsc_pkg::DEF_TEST;
      block_enables <= rfsc_pkg::DEF_BLOCK_EN;
      loop_filter_pump <= rfsc_pkg::DEF_LOOP_PUMP;
      rf_enable_control <= rfsc_pkg::DEF_RF_SECTION_ENABLE_PIN;
      pll_word <= {rfsc_pkg::DEF0_FB_HIGH, rfsc_pkg::DEF0_FB_LOW, rfsc_pkg::DEF0_REF_DIV};
    end else begin
      fb_divider_high <= next_fb_divider_high;
      fb_divider_low <= next_fb_divider_low;
      ref_divider <= next_ref_divider;
      radio_config <= next_radio_config;
      test_control <= next_test_control;
      block_enables <= next_block_enables;
      loop_filter_pump <= next_loop_filter_pump;
      rf_enable_control <= next_rf_enable_control;
      pll_word <= next_pll_word;
    end
  end

  // read data for the address byte just received; unmapped reads return zero
  always_comb begin
    if (spi_addr[6:0] == rfsc_pkg::OFS_FB_HIGH) begin
      rd_data = fb_divider_high;
    end else if (spi_addr[6:0] == rfsc_pkg::OFS_FB_LOW) begin
      rd_data = fb_divider_low;
    end else if (spi_addr[6:0] == rfsc_pkg::OFS_REF_DIV) begin
      rd_data = ref_divider;
    end else if (spi_addr[6:0] == rfsc_pkg::OFS_RADIO_CFG) begin
      rd_data = radio_config;
    end else if (spi_addr[6:0] == rfsc_pkg::OFS_TEST) begin
      rd_data = test_control;
    end else if (spi_addr[6:0] == rfsc_pkg::OFS_BLOCK_EN) begin
      rd_data = block_enables;
    end else if (spi_addr[6:0] == rfsc_pkg::OFS_LOOP_PUMP) begin
      rd_data = loop_filter_pump;
    end else if (spi_addr[6:0] == rfsc_pkg::OFS_RF_SECTION_ENABLE_PIN) begin
      rd_data = rf_enable_control;
    end else begin
      rd_data = '0;
    end
  end

  // block controls
  assign rf_active = chip_enable_pin & block_enables[rfsc_pkg::BLK_ENM_BIT]
                     & (rf_enable_control[rfsc_pkg::RFE_BIT] | rf_section_enable_pin);

  always_comb begin
    next_ctrl.chip_active = chip_enable_pin;
    next_ctrl.rf_chain_on = rf_active;
    next_ctrl.vco_on = rf_active & block_enables[rfsc_pkg::BLK_VCO_BIT];
    next_ctrl.pll_on = rf_active & block_enables[rfsc_pkg::BLK_PLL_BIT];
    next_ctrl.rf_amp_on = rf_active & block_enables[rfsc_pkg::BLK_RFA_BIT];
    next_ctrl.mixer_on = rf_active & block_enables[rfsc_pkg::BLK_MIX_BIT];
    next_ctrl.if_chain_on = rf_active & block_enables[rfsc_pkg::BLK_IF_BIT];
    next_ctrl.agc_on = rf_active & block_enables[rfsc_pkg::BLK_AGC_BIT];
    next_ctrl.clock_out_source_select = radio_config[rfsc_pkg::CFG_SRC_BIT];
    next_ctrl.slow_slew_select = radio_config[rfsc_pkg::CFG_SLEW_BIT];
    // clock buffers survive master enable clear but not chip enable low
    next_ctrl.osc_clock_buffer_enable = chip_enable_pin
                                        & radio_config[rfsc_pkg::CFG_OSC_BIT];
    next_ctrl.sample_clock_buffer_enable = chip_enable_pin
                                           & radio_config[rfsc_pkg::CFG_SAMPLE_BIT];
    next_ctrl.if_buffer_enable = rf_active & test_control[rfsc_pkg::TEST_IFB_BIT];
    next_ctrl.loop_filter_setting = loop_filter_pump[rfsc_pkg::LOOP_LFC_LSB +: 3];
    next_ctrl.pump_current_setting = loop_filter_pump[rfsc_pkg::LOOP_LFC_LSB - 1 -: 2];
    next_ctrl.feedback_divide_ratio = pll_word[19:8];
    next_ctrl.reference_divide_ratio = pll_word[5:0];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  chk_mode_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    load_defaults && !mode_pin |=> fb_divider_low == rfsc_pkg::DEF0_FB_LOW
      && radio_config == rfsc_pkg::DEF0_RADIO_CFG)
    else $error("mode low defaults not loaded");

  chk_mode_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    load_defaults && mode_pin |=> ##1 ctrl.feedback_divide_ratio
      == {rfsc_pkg::DEF1_FB_HIGH[3:0], rfsc_pkg::DEF1_FB_LOW}
      && ctrl.reference_divide_ratio == rfsc_pkg::DEF1_REF_DIV[5:0])
    else $error("mode high divider ratios wrong");

  chk_ce_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(chip_enable_pin) |=> rf_enable_control[rfsc_pkg::RFE_BIT]
      == $past(rf_section_enable_pin) && test_control == rfsc_pkg::DEF_TEST)
    else $error("chip enable rise did not reload defaults");

  chk_pll_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr.valid && (wr.addr == rfsc_pkg::OFS_FB_LOW || wr.addr == rfsc_pkg::OFS_FB_HIGH)
      && !load_defaults |=> $stable(pll_word))
    else $error("synthesizer word changed before the third byte");

  chk_pll_apply: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr.valid && wr.addr == rfsc_pkg::OFS_REF_DIV && !load_defaults
      |=> pll_word == {$past(fb_divider_high), $past(fb_divider_low),
                       $past(wr.data) & rfsc_pkg::MASK_REF_DIV})
    else $error("synthesizer word not applied on third byte");

  chk_chip_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !chip_enable_pin |=> !ctrl.chip_active && !ctrl.rf_chain_on
      && !ctrl.osc_clock_buffer_enable && !ctrl.sample_clock_buffer_enable)
    else $error("function active while chip disabled");

  chk_rf_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl.rf_chain_on |-> $past(chip_enable_pin && block_enables[rfsc_pkg::BLK_ENM_BIT]
      && (rf_enable_control[rfsc_pkg::RFE_BIT] || rf_section_enable_pin)))
    else $error("radio chain on without its enables");

  chk_rf_pin_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rf_section_enable_pin && !rf_enable_control[rfsc_pkg::RFE_BIT]
      |=> !ctrl.rf_chain_on && !ctrl.pll_on)
    else $error("radio or synthesizer on with enable pin low");

  chk_enm_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    chip_enable_pin && !block_enables[rfsc_pkg::BLK_ENM_BIT] |=> !ctrl.mixer_on
      && !ctrl.vco_on && ctrl.sample_clock_buffer_enable
        == $past(radio_config[rfsc_pkg::CFG_SAMPLE_BIT]))
    else $error("master enable clear handled wrongly");

  chk_clk_src: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(radio_config) |=> ctrl.clock_out_source_select
      == $past(radio_config[rfsc_pkg::CFG_SRC_BIT]))
    else $error("clock source select not following its bit");

  chk_if_buffer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rf_active && test_control[rfsc_pkg::TEST_IFB_BIT] |=> ctrl.if_buffer_enable)
    else $error("intermediate buffer not switched on");

endmodule

/* test/rfsc_master.sv */
/*
  rfsc_master: serial controller model that frames address and data bytes.
  Assumes sys_clk from the bench; each serial clock level lasts three sys_clk cycles.
*/
`timescale 1ns/100ps
module rfsc_master (
  // clock
  input wire logic sys_clk,
  // serial pins
  output logic spi_cs_n,
  output logic spi_sck,
  output logic serial_data_in_pin,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  // status
  output logic drove_early
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    serial_data_in_pin = 1'b0;
    drove_early = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // address byte then data byte, msb first; read data taken before each rising clock
  task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] bits;
    bits = {a, d};
    q = 8'h00;
    spi_cs_n = 1'b0;
    for (int k = 15; k >= 0; k--) begin
      spi_sck = 1'b0;
      serial_data_in_pin = bits[k];
      step(3);
      if ((k >= 8 || !a[7]) && spi_sdo_oe !== 1'b0) drove_early = 1'b1;
      if (k < 8) q[k] = spi_sdo_oe ? spi_sdo : 1'bx;
      spi_sck = 1'b1;
      step(3);
    end
    spi_sck = 1'b0;
    // released data line shows the inverse of its last value
    serial_data_in_pin = ~serial_data_in_pin;
    step(3);
    spi_cs_n = 1'b1;
    step(3);
  endtask
endmodule

/* test/rfsc_bench.sv */
/*
  rfsc_bench: register reads and writes through the serial port with expected values.
  Assumes rfsc_master drives the serial pins and the design runs from sys_clk only.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module rfsc_bench;
  logic sys_clk, rst_n, mode_pin, rf_section_enable_pin, chip_enable_pin;
  logic spi_cs_n, spi_sck, serial_data_in_pin, spi_sdo, spi_sdo_oe, drove_early;
  logic [23:0] pll_word;
  rfsc_pkg::rfsc_ctrl_type ctrl;
  logic [7:0] q;
  int n_mismatch = 0;
  int compares = 0;
  rfsc_top rfsc_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .mode_pin(mode_pin),
    .rf_section_enable_pin(rf_section_enable_pin), .chip_enable_pin(chip_enable_pin),
    .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .serial_data_in_pin(serial_data_in_pin),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .pll_word(pll_word), .ctrl(ctrl));
  rfsc_master rfsc_master_i (.sys_clk(sys_clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .serial_data_in_pin(serial_data_in_pin), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .drove_early(drove_early));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    rfsc_master_i.frame(a, d, dummy);
  endtask
  task automatic rd(input logic [7:0] a);
    rfsc_master_i.frame(a, 8'h00, q);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end
  initial begin
    rst_n = 1'b0;
    mode_pin = 1'b0;
    rf_section_enable_pin = 1'b1;
    chip_enable_pin = 1'b1;
    rfsc_master_i.step(5);
    rst_n = 1'b1;
    rfsc_master_i.step(4);
    `CHK("pll_word mode0", 24'h006001, pll_word)
    rd(8'hc3); `CHK("radio_config", 8'h4a, q)
    rd(8'hd1); `CHK("block_enables", 8'hff, q)
    rd(8'he0); `CHK("rf_enable_control", 8'h80, q)
    rd(8'hd0); `CHK("test_control", 8'h00, q)
    rd(8'hd5); `CHK("unmapped", 8'h00, q)
    `CHK("sdo_oe idle", 1'b0, spi_sdo_oe)
    // divider bytes held until the reference byte is written
    wr(8'h40, 8'hf5);
    wr(8'h41, 8'haa);
    `CHK("pll_word held", 24'h006001, pll_word)
    rd(8'hc0); `CHK("fb_divider_high held", 8'h05, q)
    rd(8'hc1); `CHK("fb_divider_low held", 8'haa, q)
    wr(8'h42, 8'hff);
    `CHK("pll_word applied", 24'h05aa3f, pll_word)
    `CHK("feedback ratio", 12'h5aa, ctrl.feedback_divide_ratio)
    `CHK("reference ratio", 6'h3f, ctrl.reference_divide_ratio)
    wr(8'h50, 8'h01);
    `CHK("if buffer", 1'b1, ctrl.if_buffer_enable)
    wr(8'h43, 8'h4b);
    `CHK("clock source", 1'b1, ctrl.clock_out_source_select)
    `CHK("slow slew", 1'b1, ctrl.slow_slew_select)
    `CHK("osc buffer mode0", 1'b0, ctrl.osc_clock_buffer_enable)
    rd(8'hd2); `CHK("loop_filter_pump default", 8'h00, q)
    wr(8'h52, 8'h9b);
    rd(8'hd2); `CHK("loop_filter_pump", 8'h1b, q)
    `CHK("loop filter", 3'h6, ctrl.loop_filter_setting)
    `CHK("pump current", 2'h3, ctrl.pump_current_setting)
    wr(8'h55, 8'h12);
    rd(8'hd5); `CHK("unmapped write", 8'h00, q)
    wr(8'h51, 8'hea);
    `CHK("vco", 1'b0, ctrl.vco_on)
    `CHK("pll", 1'b1, ctrl.pll_on)
    `CHK("rf amp", 1'b0, ctrl.rf_amp_on)
    `CHK("mixer", 1'b1, ctrl.mixer_on)
    `CHK("if chain", 1'b0, ctrl.if_chain_on)
    `CHK("agc", 1'b1, ctrl.agc_on)
    wr(8'h51, 8'h7f);
    `CHK("chain off by master", 1'b0, ctrl.rf_chain_on)
    `CHK("sample buffer kept", 1'b1, ctrl.sample_clock_buffer_enable)
    wr(8'h51, 8'hff);
    wr(8'h60, 8'h00);
    rf_section_enable_pin = 1'b0;
    rfsc_master_i.step(4);
    `CHK("chain off by pin", 1'b0, ctrl.rf_chain_on)
    `CHK("pll off by pin", 1'b0, ctrl.pll_on)
    wr(8'h60, 8'h80);
    `CHK("chain on by bit", 1'b1, ctrl.rf_chain_on)
    chip_enable_pin = 1'b0;
    rfsc_master_i.step(4);
    `CHK("chip off", 1'b0, ctrl.chip_active)
    mode_pin = 1'b1;
    chip_enable_pin = 1'b1;
    rfsc_master_i.step(4);
    `CHK("chip on", 1'b1, ctrl.chip_active)
    `CHK("pll_word mode1", 24'h061313, pll_word)
    `CHK("osc buffer mode1", 1'b1, ctrl.osc_clock_buffer_enable)
    rd(8'hc3); `CHK("radio_config mode1", 8'h4f, q)
    rd(8'he0); `CHK("rfe follows pin", 8'h00, q)
    `CHK("sdo driven early", 1'b0, drove_early)
    results();
  end
endmodule
